//--- hw/pid_reg_pkg.sv
// constants, register map and types for the process pid regulator
// assumes a 200 mhz system clock and a 32-bit ahb-lite register bus
package pid_reg_pkg;
   // regulator sample period and derived cycle count
   localparam int CLK_MHZ     = 200;
   localparam int TICK_US     = 10000;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   // datapath shaping
   localparam int KP_FRAC = 8;
   localparam int S_W     = 48;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_SP1      = 8'h04;
   localparam logic [7:0] OFS_SP2      = 8'h08;
   localparam logic [7:0] OFS_REFMIN   = 8'h0c;
   localparam logic [7:0] OFS_REFMAX   = 8'h10;
   localparam logic [7:0] OFS_BUSFB1   = 8'h14;
   localparam logic [7:0] OFS_BUSFB2   = 8'h18;
   localparam logic [7:0] OFS_HANDOVER = 8'h1c;
   localparam logic [7:0] OFS_KP       = 8'h20;
   localparam logic [7:0] OFS_TI       = 8'h24;
   localparam logic [7:0] OFS_TD       = 8'h28;
   localparam logic [7:0] OFS_STATUS   = 8'h2c;
   localparam logic [7:0] OFS_DEV      = 8'h30;
   // control register fields
   localparam int CB_CLOSED = 0;
   localparam int CB_INV    = 1;
   localparam int CB_CLAMP  = 2;
   localparam int CB_RUN    = 3;
   localparam int CB_SEL    = 4;
   // feedback_combine_select codes
   localparam logic [3:0] CMB_MIN  = 4'h0;
   localparam logic [3:0] CMB_MAX  = 4'h1;
   localparam logic [3:0] CMB_SUM  = 4'h2;
   localparam logic [3:0] CMB_DIFF = 4'h3;
   localparam logic [3:0] CMB_AVG  = 4'h4;
   localparam logic [3:0] CMB_ZMAX = 4'h5;
   localparam logic [3:0] CMB_ZMIN = 4'h6;
   localparam logic [3:0] CMB_FB1  = 4'h7;
   localparam logic [3:0] CMB_FB2  = 4'h8;
   // setting limits: gain q4.8, times in 10 ms ticks
   localparam logic [11:0] KP_MAX = 12'ha00;
   localparam logic [19:0] TI_MAX = 20'hf41dc;
   localparam logic [9:0]  TD_MAX = 10'h3e8;
   localparam logic signed [47:0] DEMAND_MAX = 48'sh0000_0000_ffff;
   typedef enum logic [1:0] {PH_IDLE, PH_OPEN, PH_CLOSED} phase_e;
endpackage

//--- hw/process_pid_feedback_regulator.sv
// process pid regulator: feedback combiner, setpoint choice, pid loop
// assumes feedback, limits and frequency come from logic on clk_sys
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module process_pid_feedback_regulator #(
   parameter int TICK_CYCLES = pid_reg_pkg::TICK_CYCLES
)(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // ahb-lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic [31:0]             hrdata,
   output logic                    hresp,
   // process inputs
   input  wire logic signed [15:0] analogFb1,
   input  wire logic signed [15:0] analogFb2,
   input  wire logic signed [15:0] remoteRef,
   input  wire logic [15:0]        freqActual,
   input  wire logic               currentLimit,
   input  wire logic               voltageLimit,
   input  wire logic               freqBoundHit,
   // output stage
   output logic [15:0]             freqDemand,
   output logic                    forceClockwise,
   output logic                    regulatorActive
);

   typedef struct packed {
      logic                    closedLoop;
      logic                    inverse;
      logic                    clampEn;
      logic                    runCmd;
      logic [3:0]              sel;
      logic signed [15:0]      sp1;
      logic signed [15:0]      sp2;
      logic signed [15:0]      refMin;
      logic signed [15:0]      refMax;
      logic signed [15:0]      busFb1;
      logic signed [15:0]      busFb2;
      logic [15:0]             handover;
      logic [11:0]             kp;
      logic [19:0]             ti;
      logic [9:0]              td;
      logic                    aWr;
      logic [7:0]              aAddr;
      logic [31:0]             rdata;
      logic [31:0]             tickCnt;
      pid_reg_pkg::phase_e     phase;
      logic signed [47:0]      integ;
      logic signed [23:0]      pe;
      logic signed [23:0]      pePrev;
      logic signed [24:0]      peDelta;
      logic signed [18:0]      lastDev;
      logic                    clampNeg;
      logic                    disengaged;
      logic                    divBusy;
      logic                    divNeg;
      logic [5:0]              divCnt;
      logic [20:0]             rem;
      logic [47:0]             quot;
      logic                    calcDue;
      logic [15:0]             demand;
   } state_s;

   localparam state_s RST_VAL = '{clampEn: 1'b1, phase: pid_reg_pkg::PH_IDLE, default: '0};

   state_s                  st;
   state_s                  next_st;
   logic                    busReq;
   logic                    tick;
   logic                    anyLimit;
   logic signed [15:0]      sp1c;
   logic signed [15:0]      sp2c;
   logic signed [16:0]      fb1;
   logic signed [16:0]      fb2;
   logic signed [16:0]      r1;
   logic signed [16:0]      r2;
   logic signed [18:0]      d1;
   logic signed [18:0]      d2;
   logic signed [17:0]      fbSel;
   logic signed [18:0]      devRaw;
   logic signed [18:0]      devNow;
   logic signed [31:0]      prod;
   logic signed [23:0]      peNow;
   logic signed [47:0]      loadInteg;
   logic signed [47:0]      iTerm;
   logic signed [47:0]      sumNow;
   logic signed [47:0]      sNew;
   logic [20:0]             remSh;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   function automatic logic signed [15:0] clampRef(input logic signed [15:0] v,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [15:0] clampDemand(input logic signed [47:0] v);
      return (v < 0) ? 16'h0000 : ((v > pid_reg_pkg::DEMAND_MAX) ? 16'hffff : v[15:0]);
   endfunction

   function automatic logic [31:0] rdReg(input state_s v, input logic [7:0] a);
      logic [31:0] r;
      r = '0;
      case (a)
         pid_reg_pkg::OFS_CTRL:     r = {24'h0, v.sel, v.runCmd, v.clampEn, v.inverse, v.closedLoop};
         pid_reg_pkg::OFS_SP1:      r = 32'(v.sp1);
         pid_reg_pkg::OFS_SP2:      r = 32'(v.sp2);
         pid_reg_pkg::OFS_REFMIN:   r = 32'(v.refMin);
         pid_reg_pkg::OFS_REFMAX:   r = 32'(v.refMax);
         pid_reg_pkg::OFS_BUSFB1:   r = 32'(v.busFb1);
         pid_reg_pkg::OFS_BUSFB2:   r = 32'(v.busFb2);
         pid_reg_pkg::OFS_HANDOVER: r = {16'h0, v.handover};
         pid_reg_pkg::OFS_KP:       r = {20'h0, v.kp};
         pid_reg_pkg::OFS_TI:       r = {12'h0, v.ti};
         pid_reg_pkg::OFS_TD:       r = {22'h0, v.td};
         pid_reg_pkg::OFS_STATUS:   r = {13'h0, v.disengaged, v.phase, v.demand};
         pid_reg_pkg::OFS_DEV:      r = 32'(v.lastDev);
         default:                   r = '0;
      endcase
      return r;
   endfunction

   // zero wait states, so a read sees writes that land on the same edge
   assign busReq    = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st.rdata;
   assign tick      = (st.tickCnt == 32'(TICK_CYCLES - 1));
   assign anyLimit  = currentLimit | voltageLimit | freqBoundHit;

   assign sp1c = clampRef(st.sp1, st.refMin, st.refMax);
   assign sp2c = clampRef(st.sp2, st.refMin, st.refMax);
   assign fb1  = 17'(st.busFb1) + 17'(analogFb1);
   assign fb2  = 17'(st.busFb2) + 17'(analogFb2);
   assign r1   = 17'(sp1c) + 17'(remoteRef);
   assign r2   = 17'(sp2c) + 17'(remoteRef);
   assign d1   = 19'(r1) - 19'(fb1);
   assign d2   = 19'(r2) - 19'(fb2);

   always_comb
   begin
      fbSel  = 18'(fb1);
      devRaw = d1;
      case (st.sel)
         pid_reg_pkg::CMB_MIN:  fbSel = (fb1 < fb2) ? 18'(fb1) : 18'(fb2);
         pid_reg_pkg::CMB_MAX:  fbSel = (fb1 > fb2) ? 18'(fb1) : 18'(fb2);
         pid_reg_pkg::CMB_SUM:  fbSel = 18'(fb1) + 18'(fb2);
         pid_reg_pkg::CMB_DIFF: fbSel = 18'(fb2) - 18'(fb1);
         pid_reg_pkg::CMB_AVG:  fbSel = (18'(fb1) + 18'(fb2)) >>> 1;
         pid_reg_pkg::CMB_FB2:  fbSel = 18'(fb2);
         default:               fbSel = 18'(fb1);
      endcase
      unique case (st.sel)
         // larger zone difference with its setpoint
         pid_reg_pkg::CMB_ZMAX: devRaw = (d1 >= d2) ? d1 : d2;
         // smaller zone difference with its setpoint
         pid_reg_pkg::CMB_ZMIN: devRaw = (d1 <= d2) ? d1 : d2;
         pid_reg_pkg::CMB_FB2:  devRaw = 19'(r2) - 19'(fbSel);
         // setpoint one, also taken for unused codes
         default:               devRaw = 19'(r1) - 19'(fbSel);
      endcase
   end

   assign devNow = st.inverse ? -devRaw : devRaw;
   assign prod  = $signed({1'b0, st.kp}) * devNow;
   assign peNow = 24'(prod >>> pid_reg_pkg::KP_FRAC);
   // integrator value that makes the output equal the actual frequency
   assign loadInteg = (48'($signed({1'b0, freqActual})) - 48'(peNow))
                      * 48'($signed({1'b0, st.ti}));
   assign iTerm = st.divNeg ? -$signed(st.quot) : $signed(st.quot);
   // derivative scaled by time, summed with the other terms
   assign sumNow = 48'(st.pe) + iTerm + 48'(st.peDelta) * 48'($signed({1'b0, st.td}));
   assign remSh  = {st.rem[19:0], st.quot[47]};

   assign freqDemand      = st.demand;
   assign forceClockwise  = (st.phase == pid_reg_pkg::PH_OPEN);
   assign regulatorActive = (st.phase == pid_reg_pkg::PH_CLOSED) & ~st.disengaged;

   always_comb
   begin
      next_st = st;
      sNew    = st.integ;
      // bus data phase
      if (st.aWr)
      begin
         case (st.aAddr)
            pid_reg_pkg::OFS_CTRL:
            begin
               next_st.closedLoop = hwdata[pid_reg_pkg::CB_CLOSED];
               next_st.inverse    = hwdata[pid_reg_pkg::CB_INV];
               next_st.clampEn    = hwdata[pid_reg_pkg::CB_CLAMP];
               next_st.runCmd     = hwdata[pid_reg_pkg::CB_RUN];
               next_st.sel        = hwdata[pid_reg_pkg::CB_SEL +: 4];
            end
            pid_reg_pkg::OFS_SP1:      next_st.sp1 = hwdata[15:0];
            pid_reg_pkg::OFS_SP2:      next_st.sp2 = hwdata[15:0];
            pid_reg_pkg::OFS_REFMIN:   next_st.refMin = hwdata[15:0];
            pid_reg_pkg::OFS_REFMAX:   next_st.refMax = hwdata[15:0];
            pid_reg_pkg::OFS_BUSFB1:   next_st.busFb1 = hwdata[15:0];
            pid_reg_pkg::OFS_BUSFB2:   next_st.busFb2 = hwdata[15:0];
            pid_reg_pkg::OFS_HANDOVER: next_st.handover = hwdata[15:0];
            pid_reg_pkg::OFS_KP:
               next_st.kp = (hwdata[31:12] != '0 || hwdata[11:0] > pid_reg_pkg::KP_MAX)
                            ? pid_reg_pkg::KP_MAX : hwdata[11:0];
            // integral time capped, zero means off
            pid_reg_pkg::OFS_TI:
               next_st.ti = (hwdata[31:20] != '0 || hwdata[19:0] > pid_reg_pkg::TI_MAX)
                            ? pid_reg_pkg::TI_MAX : hwdata[19:0];
            // derivative time capped, zero means off
            pid_reg_pkg::OFS_TD:
               next_st.td = (hwdata[31:10] != '0 || hwdata[9:0] > pid_reg_pkg::TD_MAX)
                            ? pid_reg_pkg::TD_MAX : hwdata[9:0];
            default: ;
         endcase
      end
      next_st.aWr   = busReq & hwrite;
      next_st.aAddr = haddr[7:0];
      if (busReq & ~hwrite)
      begin
         next_st.rdata = rdReg(next_st, haddr[7:0]);
      end
      next_st.tickCnt = tick ? '0 : st.tickCnt + 32'h1;
      // serial divider for the integral term, far shorter than a tick
      next_st.calcDue = 1'b0;
      if (st.divBusy)
      begin
         if (remSh >= {1'b0, st.ti})
         begin
            next_st.rem  = remSh - {1'b0, st.ti};
            next_st.quot = {st.quot[46:0], 1'b1};
         end
         else
         begin
            next_st.rem  = remSh;
            next_st.quot = {st.quot[46:0], 1'b0};
         end
         next_st.divCnt = st.divCnt - 6'h1;
         if (st.divCnt == 6'h1)
         begin
            next_st.divBusy = 1'b0;
            next_st.calcDue = 1'b1;
         end
      end
      // clamp disabled leaves the integrator free
      if (~st.clampEn)
      begin
         next_st.disengaged = 1'b0;
      end
      unique case (st.phase)
         pid_reg_pkg::PH_IDLE:
         begin
            // open loop configuration passes the remote reference
            next_st.demand = (st.runCmd & ~st.closedLoop)
                             ? clampDemand(48'(remoteRef)) : 16'h0000;
            if (st.runCmd & st.closedLoop)
            begin
               next_st.phase = pid_reg_pkg::PH_OPEN;
            end
         end
         pid_reg_pkg::PH_OPEN:
         begin
            // open loop toward the handover frequency
            next_st.demand = st.handover;
            if (~st.runCmd | ~st.closedLoop)
            begin
               next_st.phase = pid_reg_pkg::PH_IDLE;
            end
            else if (freqActual >= st.handover && ~currentLimit)
            begin
               next_st.phase      = pid_reg_pkg::PH_CLOSED;
               next_st.integ      = 48'($signed({1'b0, st.handover}))
                                    * 48'($signed({1'b0, st.ti}));
               next_st.disengaged = 1'b0;
               next_st.pePrev     = peNow;
            end
         end
         pid_reg_pkg::PH_CLOSED:
         begin
            if (~st.runCmd | ~st.closedLoop)
            begin
               next_st.phase = pid_reg_pkg::PH_IDLE;
            end
            else if (tick)
            begin
               next_st.pe      = peNow;
               next_st.pePrev  = peNow;
               next_st.peDelta = 25'(peNow) - 25'(st.pePrev);
               next_st.lastDev = devNow;
               // engage the clamp at any limit
               if (st.clampEn & anyLimit & ~st.disengaged)
               begin
                  sNew               = loadInteg;
                  next_st.disengaged = 1'b1;
                  next_st.clampNeg   = devNow[18];
               end
               // hold off until deviation is zero or changes sign
               else if (st.disengaged & st.clampEn)
               begin
                  if (devNow == '0 || devNow[18] != st.clampNeg)
                  begin
                     next_st.disengaged = 1'b0;
                     sNew               = st.integ + 48'(peNow);
                  end
                  else
                  begin
                     sNew = loadInteg;
                  end
               end
               else if (st.ti != '0)
               begin
                  sNew = st.integ + 48'(peNow);
               end
               next_st.integ = sNew;
               // integral is accumulated proportional over time in ticks
               if (st.ti != '0)
               begin
                  next_st.divBusy = 1'b1;
                  next_st.divCnt  = 6'(pid_reg_pkg::S_W);
                  next_st.rem     = '0;
                  next_st.divNeg  = sNew[47];
                  next_st.quot    = sNew[47] ? 48'(-sNew) : 48'(sNew);
               end
               else
               begin
                  next_st.calcDue = 1'b1;
                  next_st.quot    = '0;
                  next_st.divNeg  = 1'b0;
               end
            end
            // demand is the pid sum, or the actual frequency while held
            if (st.calcDue)
            begin
               next_st.demand = st.disengaged ? freqActual : clampDemand(sumNow);
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st <= RST_VAL;
      end
      else
      begin
         st <= next_st;
      end
   end

   a_min_pick: assert property (
      st.sel == pid_reg_pkg::CMB_MIN |-> fbSel <= 18'(fb1) && fbSel <= 18'(fb2))
      else $error("min mode did not pick the lower feedback");
   a_zone_larger: assert property (
      st.sel == pid_reg_pkg::CMB_ZMAX |-> devRaw >= d1 && devRaw >= d2)
      else $error("zone mode did not pick the larger difference");
   a_zone_smaller: assert property (
      st.sel == pid_reg_pkg::CMB_ZMIN |-> devRaw <= d1 && devRaw <= d2)
      else $error("zone mode did not pick the smaller difference");
   a_setpoint_bound: assert property (
      st.refMin <= st.refMax |-> sp1c >= st.refMin && sp1c <= st.refMax
      && sp2c >= st.refMin && sp2c <= st.refMax)
      else $error("setpoint outside reference limits");
   a_clamp_engage: assert property (
      tick && st.phase == pid_reg_pkg::PH_CLOSED && st.runCmd && st.closedLoop
      && st.clampEn && anyLimit && !st.disengaged
      |=> st.disengaged && st.integ == $past(loadInteg))
      else $error("clamp did not load the integrator");
   a_clamp_release: assert property (
      tick && st.phase == pid_reg_pkg::PH_CLOSED && st.runCmd && st.closedLoop
      && st.disengaged && devNow == '0 |=> !st.disengaged)
      else $error("regulator stayed disengaged at zero deviation");
   a_hold_limit: assert property (
      st.phase == pid_reg_pkg::PH_OPEN && currentLimit |=> st.phase != pid_reg_pkg::PH_CLOSED)
      else $error("regulator closed while at current limit");
   a_start_cw: assert property (
      $rose(st.phase == pid_reg_pkg::PH_OPEN) |-> forceClockwise ##1 forceClockwise
      || st.phase != pid_reg_pkg::PH_OPEN)
      else $error("handover not clockwise");
   a_open_demand: assert property (
      st.phase == pid_reg_pkg::PH_OPEN ##1 st.phase == pid_reg_pkg::PH_OPEN
      |-> freqDemand == $past(st.handover))
      else $error("open loop demand is not the handover frequency");
   a_div_time: assert property (
      $rose(st.divBusy) |-> ##48 st.calcDue)
      else $error("integral division took the wrong time");
   a_idle_zero: assert property (
      st.phase == pid_reg_pkg::PH_IDLE && st.closedLoop |=> freqDemand == 16'h0000)
      else $error("demand not zero while idle in closed loop");

   c_closed: cover property ($rose(st.phase == pid_reg_pkg::PH_CLOSED));
   c_disengage: cover property ($rose(st.disengaged));
   c_release: cover property ($fell(st.disengaged) && st.phase == pid_reg_pkg::PH_CLOSED);
   c_zone_tick: cover property (tick && st.sel == pid_reg_pkg::CMB_ZMAX && devRaw == d2);

endmodule // process_pid_feedback_regulator

//--- testbench/motor_stage_model.sv
// motor output stage stand-in: output frequency slews toward the demand
// assumes the regulator's clk_sys and its active-high asynchronous reset
`timescale 1ns/1ps
module motor_stage_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // demand in, stall request from the bench
   input  wire logic [15:0] freqDemand,
   input  wire logic        stall,
   // state back to the regulator
   output logic      [15:0] freqActual,
   output logic             currentLimit
);
   assign currentLimit = stall;
   // held at current limit the speed cannot move; else slew 8 per cycle
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         freqActual <= 16'h0;
      else if (!stall)
         freqActual <= (freqDemand > freqActual + 16'h8) ? freqActual + 16'h8 :
                       (freqDemand + 16'h8 < freqActual) ? freqActual - 16'h8 : freqDemand;
endmodule // motor_stage_model

//--- testbench/tb.sv
// testbench: ahb-lite master, feedback drive and checks of the regulator
// assumes the motor stage model and a short regulator tick of 100 cycles
`timescale 1ns/1ps
module tb;
   logic clk_sys, rst, hsel, hwrite, voltageLimit, stall, forceClockwise, regulatorActive;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic        hreadyout, hresp, currentLimit, freqBoundHit;
   logic signed [15:0] analogFb1, analogFb2, remoteRef;
   logic [15:0] freqActual, freqDemand;
   int error_cnt, num_checks;
   // deviations per combine code: sp1 500, sp2 300, fb1 200, fb2 100, ref 10
   logic [31:0] expDev [0:8] = '{32'h19a, 32'h136, 32'hd2, 32'h262, 32'h168,
                                 32'h136, 32'hd2, 32'h136, 32'hd2};
   process_pid_feedback_regulator #(.TICK_CYCLES(100)) process_pid_feedback_regulator_inst (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .analogFb1(analogFb1),
      .analogFb2(analogFb2), .remoteRef(remoteRef), .freqActual(freqActual),
      .currentLimit(currentLimit), .voltageLimit(voltageLimit), .freqBoundHit(freqBoundHit),
      .freqDemand(freqDemand), .forceClockwise(forceClockwise),
      .regulatorActive(regulatorActive));
   motor_stage_model motor_stage_model_inst (.clk_sys(clk_sys), .rst(rst),
      .freqDemand(freqDemand), .stall(stall), .freqActual(freqActual),
      .currentLimit(currentLimit));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one single word transfer; the answer decides how long each phase lasts
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic t_reset;
      rdchk(pid_reg_pkg::OFS_CTRL, 32'h4);
      rdchk(pid_reg_pkg::OFS_SP1, 32'h0);
      rdchk(8'h40, 32'h0);
   endtask
   task automatic t_handover;
      int n;
      wr(pid_reg_pkg::OFS_REFMAX, 32'h3e8);
      wr(pid_reg_pkg::OFS_SP1, 32'h1f4);
      wr(pid_reg_pkg::OFS_SP2, 32'h12c);
      wr(pid_reg_pkg::OFS_BUSFB1, 32'h64);
      wr(pid_reg_pkg::OFS_BUSFB2, 32'h32);
      wr(pid_reg_pkg::OFS_HANDOVER, 32'h1f4);
      stall <= 1'b1;
      wr(pid_reg_pkg::OFS_CTRL, 32'hd);
      repeat (250) @(posedge clk_sys);
      chk({31'h0, regulatorActive}, 32'h0);
      chk({31'h0, forceClockwise}, 32'h1);
      chk({16'h0, freqDemand}, 32'h1f4);
      stall <= 1'b0;
      for (n = 0; n < 300 && regulatorActive !== 1'b1; n++) @(posedge clk_sys);
      chk({31'h0, regulatorActive}, 32'h1);
      chk({31'h0, forceClockwise}, 32'h0);
   endtask
   // every combine code in turn, deviation read after a full tick
   task automatic t_combine;
      logic [31:0] q;
      for (int i = 0; i < 9; i++)
      begin
         wr(pid_reg_pkg::OFS_CTRL, {24'h0, 4'(i), 4'hd});
         repeat (170) @(posedge clk_sys);
         bus(1'b0, pid_reg_pkg::OFS_DEV, 32'h0, q);
         if (i < 3)
            chk(q, expDev[i]);
         else if (i < 6)
            chk(q, expDev[i]);
         else
            chk(q, expDev[i]);
      end
      wr(pid_reg_pkg::OFS_CTRL, 32'h7f);
      repeat (170) @(posedge clk_sys);
      rdchk(pid_reg_pkg::OFS_DEV, 32'hfffffeca);
   endtask
   task automatic t_gain_windup;
      logic [31:0] q;
      wr(pid_reg_pkg::OFS_CTRL, 32'h0);
      wr(pid_reg_pkg::OFS_HANDOVER, 32'h0);
      wr(pid_reg_pkg::OFS_KP, 32'h200);
      wr(pid_reg_pkg::OFS_CTRL, 32'h7d);
      repeat (170) @(posedge clk_sys);
      chk({16'h0, freqDemand}, 32'h26c);
      voltageLimit <= 1'b1;
      // a doubled gain must not move the demand while held
      wr(pid_reg_pkg::OFS_KP, 32'h400);
      repeat (170) @(posedge clk_sys);
      bus(1'b0, pid_reg_pkg::OFS_STATUS, 32'h0, q);
      chk({31'h0, q[18]}, 32'h1);
      chk({16'h0, freqDemand}, {16'h0, freqActual});
      chk({16'h0, freqDemand}, 32'h26c);
      // setpoint 190 gives zero deviation, which releases the hold
      voltageLimit <= 1'b0;
      wr(pid_reg_pkg::OFS_SP1, 32'hbe);
      repeat (170) @(posedge clk_sys);
      bus(1'b0, pid_reg_pkg::OFS_STATUS, 32'h0, q);
      chk({31'h0, q[18]}, 32'h0);
      chk({31'h0, regulatorActive}, 32'h1);
      chk({16'h0, freqDemand}, 32'h0);
   endtask
   task automatic wait_demand(output logic [15:0] d);
      logic [15:0] p;
      p = freqDemand;
      for (int n = 0; n < 200 && freqDemand === p; n++) @(posedge clk_sys);
      d = freqDemand;
   endtask
   // gain 1.0, integral time 2 ticks, clamp off while the voltage and frequency bound limits are up
   task automatic t_integral;
      logic [15:0] d0;
      logic [15:0] d1;
      logic [15:0] d2;
      logic [15:0] d3;
      wr(pid_reg_pkg::OFS_CTRL, 32'h0);
      wr(pid_reg_pkg::OFS_SP1, 32'h1f4);
      wr(pid_reg_pkg::OFS_KP, 32'h100);
      wr(pid_reg_pkg::OFS_TI, 32'h2);
      wr(pid_reg_pkg::OFS_TD, 32'h5);
      voltageLimit <= 1'b1;
      freqBoundHit <= 1'b1;
      wr(pid_reg_pkg::OFS_CTRL, 32'h79);
      wait_demand(d0);
      wait_demand(d1);
      wait_demand(d2);
      chk({16'h0, d0}, 32'h1d1);
      chk({16'h0, d2 - d0}, 32'h136);
      chk({31'h0, regulatorActive}, 32'h1);
      // deviation steps by 10: derivative adds 10 times 5 once
      wr(pid_reg_pkg::OFS_SP1, 32'h1fe);
      wait_demand(d3);
      chk({16'h0, d3 - d2}, 32'hdc);
      voltageLimit <= 1'b0;
      freqBoundHit <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #200000;
      error_cnt++;
      end_of_test();
   end
   initial
   begin
      rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
      hwdata = 32'h0; voltageLimit = 1'b0; stall = 1'b0;
      freqBoundHit = 1'b0;
      analogFb1 = 16'sh64; analogFb2 = 16'sh32; remoteRef = 16'sha;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_handover();
      t_combine();
      t_gain_windup();
      t_integral();
      end_of_test();
   end
endmodule // tb
